/* logic/adcscd_pkg.sv */
package adcscd_pkg;

  // reference clock and analog timing
  localparam int REF_CLK_MHZ = 25;
  localparam int BREAK_NS    = 40;
  localparam int SAMPLE_NS   = 480;
  localparam int SETTLE_NS   = 120;

  // least times, rounded up to whole cycles
  localparam logic [3:0] BREAK_CYC  =
    4'((BREAK_NS * REF_CLK_MHZ + 999) / 1000);
  localparam logic [3:0] SAMPLE_CYC =
    4'((SAMPLE_NS * REF_CLK_MHZ + 999) / 1000);
  localparam logic [3:0] SETTLE_CYC =
    4'((SETTLE_NS * REF_CLK_MHZ + 999) / 1000);

  // frame layout
  localparam logic [4:0] CMD_BITS   = 5'h04;
  localparam logic [4:0] CMD_LAST   = 5'h03;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam int         DATA_W     = 12;
  localparam logic [3:0] PAD_NIBBLE = 4'h0;

  // command codes
  localparam logic [3:0] CMD_PWRDN   = 4'h8;
  localparam logic [3:0] CMD_CFG_RD  = 4'h9;
  localparam logic [3:0] CMD_CFG_WR  = 4'ha;
  localparam logic [3:0] CMD_TST_MID = 4'hb;
  localparam logic [3:0] CMD_TST_LO  = 4'hc;
  localparam logic [3:0] CMD_TST_HI  = 4'hd;
  localparam logic [3:0] CMD_FIFO_RD = 4'he;
  localparam logic [3:0] CMD_RSVD    = 4'hf;

  // multiplexer sources beyond the analog inputs
  localparam logic [3:0] MUX_TST_MID = 4'h8;
  localparam logic [3:0] MUX_TST_LO  = 4'h9;
  localparam logic [3:0] MUX_TST_HI  = 4'ha;

  // config word fields
  localparam int          CFG_MODE_HI      = 6;
  localparam int          CFG_MODE_LO      = 5;
  localparam logic [1:0]  CFG_MODE_ONESHOT = 2'h0;
  localparam logic [11:0] CFG_RESET        = 12'h000;
  localparam logic [11:0] RESULT_RESET     = 12'h000;
  localparam logic [11:0] SAR_MSB          = 12'h800;
  localparam logic [3:0]  SAR_TOP_BIT      = 4'hb;

  typedef struct packed {
    logic [3:0]        cmd;
    logic [DATA_W-1:0] data;
  } adcscd_frame_t;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] cfg;
  } adcscd_pub_t;

endpackage

/* logic/adcscd_sync.sv */
`timescale 1ns/10ps
module adcscd_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule

/* logic/adcscd_lane.sv */
`timescale 1ns/10ps
module adcscd_lane
  import adcscd_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         cs_n_i,
  input  wire logic         lane_on_i,
  input  wire logic         use_fs_i,
  input  wire logic         frame_strobe_i,
  input  wire logic         sdi_i,
  input  wire adcscd_pub_t  pub_i,
  output adcscd_frame_t     frame_o,
  output logic              cmd_tog_o,
  output logic              frm_tog_o,
  output logic              sdo_o,
  output logic              sdo_oe_n_o
);

  logic [4:0]        cnt_q, cnt_d, oidx_q;
  logic [15:0]       shift_q, shift_d;
  logic [3:0]        cmd_q, cmd_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic              started_q, started_d;
  logic              ctog_q, ctog_d;
  logic              ftog_q, ftog_d;
  logic              go;
  logic              sel_cfg;
  logic [15:0]       word;

  always_comb begin
    cnt_d     = cnt_q;
    shift_d   = shift_q;
    cmd_d     = cmd_q;
    data_d    = data_q;
    started_d = started_q;
    ctog_d    = ctog_q;
    ftog_d    = ftog_q;
    go        = started_q | ~use_fs_i;
    if (lane_on_i) begin
      if (use_fs_i && frame_strobe_i) begin
        cnt_d     = '0;
        started_d = 1'b1;
      end else if (go && cnt_q != FRAME_BITS) begin
        shift_d = {shift_q[14:0], sdi_i};
        cnt_d   = cnt_q + 5'h01;
        if (cnt_q == CMD_LAST) begin
          cmd_d  = shift_d[3:0];
          ctog_d = ~ctog_q;
        end
        if (cnt_q == FRAME_LAST) begin
          data_d = shift_d[DATA_W-1:0];
          ftog_d = ~ftog_q;
        end
      end
    end
    sel_cfg = (oidx_q >= CMD_BITS) && (cmd_q == CMD_CFG_RD) &&
      (pub_i.cfg[CFG_MODE_HI:CFG_MODE_LO] == CFG_MODE_ONESHOT);
    if (sel_cfg)
      word = {PAD_NIBBLE, pub_i.cfg};
    else
      word = {pub_i.result, PAD_NIBBLE};
  end

  // cs high clears the frame count; constants only
  always_ff @(posedge clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_q     <= '0;
      shift_q   <= '0;
      started_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      shift_q   <= shift_d;
      started_q <= started_d;
    end
  end

  // toggles and words outlive the frame so the crossing sees one edge
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_q  <= '0;
      data_q <= '0;
      ctog_q <= 1'b0;
      ftog_q <= 1'b0;
    end else begin
      cmd_q  <= cmd_d;
      data_q <= data_d;
      ctog_q <= ctog_d;
      ftog_q <= ftog_d;
    end
  end

  // launch on the opposite edge
  always_ff @(negedge clk_i or posedge cs_n_i) begin
    if (cs_n_i)
      oidx_q <= '0;
    else
      oidx_q <= cnt_q;
  end

  assign frame_o    = '{cmd: cmd_q, data: data_q};
  assign cmd_tog_o  = ctog_q;
  assign frm_tog_o  = ftog_q;
  assign sdo_o      = word[~oidx_q[3:0]];
  assign sdo_oe_n_o = cs_n_i | ~lane_on_i | ~go |
                      (oidx_q == FRAME_BITS);

endmodule

/* logic/adcscd_top.sv */
`timescale 1ns/10ps
module adcscd_top
  import adcscd_pkg::*;
#(
  parameter bit EIGHT_CH = 1'b1
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        frame_strobe_i,
  input  wire logic        sdi_i,
  input  wire logic        comp_hi_i,
  output logic             sdo_o,
  output logic             sdo_oe_n_o,
  output logic [3:0]       mux_sel_o,
  output logic             mux_on_o,
  output logic             power_down_o,
  output logic [11:0]      dac_code_o,
  output logic [11:0]      result_o,
  output logic             result_valid_o,
  output logic             busy_o
);

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_BREAK  = 3'b001,
    S_SAMPLE = 3'b010,
    S_TRIAL  = 3'b011,
    S_DECIDE = 3'b100
  } adcscd_state_t;

  localparam int MAKE_MAX = 8;

  // link side
  logic          sclk_n;
  logic          dsp_q;
  adcscd_frame_t frame_a, frame_b;
  logic          ctog_a, ctog_b, ftog_a, ftog_b;
  logic          sdo_a, sdo_b, oe_n_a, oe_n_b;

  // reference side
  logic          ctog_a_s, ctog_b_s, ftog_a_s, ftog_b_s;
  logic          comp_s, cs_idle_s;
  logic [3:0]    tog_p_q, tog_p_d;
  logic          cmd_ev, frm_ev;
  logic [3:0]    ev_cmd, ev_fcmd;
  logic [11:0]   ev_data;
  adcscd_state_t state_q, state_d;
  logic [3:0]    tmr_q, tmr_d;
  logic [3:0]    bit_q, bit_d;
  logic [11:0]   dac_q, dac_d;
  logic [3:0]    mux_sel_q, mux_sel_d;
  logic          mux_on_q, mux_on_d;
  logic [3:0]    tgt_q, tgt_d;
  logic          pd_q, pd_d;
  logic          first_q, first_d;
  logic [11:0]   result_q, result_d;
  logic          valid_q, valid_d;
  logic [11:0]   cfg_q, cfg_d;
  logic [3:0]    last_cmd_q, last_cmd_d;
  logic          done_q, done_d;
  adcscd_pub_t   pub_q, pub_d;
  logic          start;
  logic [3:0]    start_sel;

  assign sclk_n = ~sclk_i;

  // link mode fixed at each chip select fall
  always_ff @(negedge cs_n_i) begin
    dsp_q <= ~frame_strobe_i;
  end

  adcscd_lane u_lane_spi (
    .clk_i          (sclk_i),
    .reset_i        (reset_i),
    .cs_n_i         (cs_n_i),
    .lane_on_i      (~dsp_q),
    .use_fs_i       (1'b0),
    .frame_strobe_i (frame_strobe_i),
    .sdi_i          (sdi_i),
    .pub_i          (pub_q),
    .frame_o        (frame_a),
    .cmd_tog_o      (ctog_a),
    .frm_tog_o      (ftog_a),
    .sdo_o          (sdo_a),
    .sdo_oe_n_o     (oe_n_a)
  );

  adcscd_lane u_lane_dsp (
    .clk_i          (sclk_n),
    .reset_i        (reset_i),
    .cs_n_i         (cs_n_i),
    .lane_on_i      (dsp_q),
    .use_fs_i       (1'b1),
    .frame_strobe_i (frame_strobe_i),
    .sdi_i          (sdi_i),
    .pub_i          (pub_q),
    .frame_o        (frame_b),
    .cmd_tog_o      (ctog_b),
    .frm_tog_o      (ftog_b),
    .sdo_o          (sdo_b),
    .sdo_oe_n_o     (oe_n_b)
  );

  assign sdo_o      = dsp_q ? sdo_b : sdo_a;
  assign sdo_oe_n_o = dsp_q ? oe_n_b : oe_n_a;

  adcscd_sync u_s_ca (.clk_i(ref_clk_i), .reset_i(reset_i),
                      .d_i(ctog_a), .q_o(ctog_a_s));
  adcscd_sync u_s_cb (.clk_i(ref_clk_i), .reset_i(reset_i),
                      .d_i(ctog_b), .q_o(ctog_b_s));
  adcscd_sync u_s_fa (.clk_i(ref_clk_i), .reset_i(reset_i),
                      .d_i(ftog_a), .q_o(ftog_a_s));
  adcscd_sync u_s_fb (.clk_i(ref_clk_i), .reset_i(reset_i),
                      .d_i(ftog_b), .q_o(ftog_b_s));
  adcscd_sync u_s_cmp (.clk_i(ref_clk_i), .reset_i(reset_i),
                       .d_i(comp_hi_i), .q_o(comp_s));
  adcscd_sync u_s_cs (.clk_i(ref_clk_i), .reset_i(reset_i),
                      .d_i(cs_n_i), .q_o(cs_idle_s));

  // toggle edges mark command and frame ends
  always_comb begin
    tog_p_d = {ctog_a_s, ctog_b_s, ftog_a_s, ftog_b_s};
    cmd_ev  = (ctog_a_s ^ tog_p_q[3]) | (ctog_b_s ^ tog_p_q[2]);
    frm_ev  = (ftog_a_s ^ tog_p_q[1]) | (ftog_b_s ^ tog_p_q[0]);
    ev_cmd  = (ctog_a_s ^ tog_p_q[3]) ? frame_a.cmd : frame_b.cmd;
    ev_fcmd = (ftog_a_s ^ tog_p_q[1]) ? frame_a.cmd : frame_b.cmd;
    ev_data = (ftog_a_s ^ tog_p_q[1]) ? frame_a.data : frame_b.data;
  end

  always_comb begin
    state_d    = state_q;
    tmr_d      = tmr_q;
    bit_d      = bit_q;
    dac_d      = dac_q;
    mux_sel_d  = mux_sel_q;
    mux_on_d   = mux_on_q;
    tgt_d      = tgt_q;
    pd_d       = pd_q;
    first_d    = first_q;
    result_d   = result_q;
    valid_d    = valid_q;
    cfg_d      = cfg_q;
    last_cmd_d = last_cmd_q;
    done_d     = 1'b0;
    pub_d      = pub_q;
    start      = 1'b0;
    start_sel  = '0;
    if (tmr_q != 4'h0)
      tmr_d = tmr_q - 4'h1;
    unique case (state_q)
      S_IDLE: begin
      end
      S_BREAK: begin
        if (tmr_q == 4'h0) begin
          mux_sel_d = tgt_q;
          mux_on_d  = 1'b1;
          tmr_d     = SAMPLE_CYC;
          state_d   = S_SAMPLE;
        end
      end
      S_SAMPLE: begin
        if (tmr_q == 4'h0) begin
          bit_d   = SAR_TOP_BIT;
          dac_d   = SAR_MSB;
          tmr_d   = SETTLE_CYC;
          state_d = S_TRIAL;
        end
      end
      S_TRIAL: begin
        if (tmr_q == 4'h0)
          state_d = S_DECIDE;
      end
      S_DECIDE: begin
        if (!comp_s)
          dac_d[bit_q] = 1'b0;
        if (bit_q == 4'h0) begin
          result_d = dac_d;
          valid_d  = ~first_q;
          first_d  = 1'b0;
          done_d   = 1'b1;
          state_d  = S_IDLE;
        end else begin
          bit_d        = bit_q - 4'h1;
          dac_d[bit_d] = 1'b1;
          tmr_d        = SETTLE_CYC;
          state_d      = S_TRIAL;
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (cmd_ev) begin
      last_cmd_d = ev_cmd;
      if (!ev_cmd[3]) begin
        if (EIGHT_CH || !ev_cmd[0]) begin
          start     = 1'b1;
          start_sel = EIGHT_CH ? ev_cmd : {1'b0, ev_cmd[3:1]};
        end
      end else begin
        unique case (ev_cmd)
          CMD_PWRDN: begin
            pd_d     = 1'b1;
            first_d  = 1'b1;
            mux_on_d = 1'b0;
            state_d  = S_IDLE;
          end
          CMD_TST_MID: begin
            start     = 1'b1;
            start_sel = MUX_TST_MID;
          end
          CMD_TST_LO: begin
            start     = 1'b1;
            start_sel = MUX_TST_LO;
          end
          CMD_TST_HI: begin
            start     = 1'b1;
            start_sel = MUX_TST_HI;
          end
          // read-outs are served at the link; reserved does nothing
          default: begin
          end
        endcase
      end
      if (start) begin
        tgt_d    = start_sel;
        pd_d     = 1'b0;
        mux_on_d = 1'b0;
        tmr_d    = BREAK_CYC;
        state_d  = S_BREAK;
      end
    end
    if (frm_ev && ev_fcmd == CMD_CFG_WR)
      cfg_d = ev_data;
    // words for the link change only between frames
    if (cs_idle_s)
      pub_d = '{result: result_q, cfg: cfg_q};
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tog_p_q    <= '0;
      state_q    <= S_IDLE;
      tmr_q      <= '0;
      bit_q      <= '0;
      dac_q      <= '0;
      mux_sel_q  <= '0;
      mux_on_q   <= 1'b0;
      tgt_q      <= '0;
      pd_q       <= 1'b0;
      first_q    <= 1'b1;
      result_q   <= RESULT_RESET;
      valid_q    <= 1'b0;
      cfg_q      <= CFG_RESET;
      last_cmd_q <= '0;
      done_q     <= 1'b0;
      pub_q      <= '{result: RESULT_RESET, cfg: CFG_RESET};
    end else begin
      tog_p_q    <= tog_p_d;
      state_q    <= state_d;
      tmr_q      <= tmr_d;
      bit_q      <= bit_d;
      dac_q      <= dac_d;
      mux_sel_q  <= mux_sel_d;
      mux_on_q   <= mux_on_d;
      tgt_q      <= tgt_d;
      pd_q       <= pd_d;
      first_q    <= first_d;
      result_q   <= result_d;
      valid_q    <= valid_d;
      cfg_q      <= cfg_d;
      last_cmd_q <= last_cmd_d;
      done_q     <= done_d;
      pub_q      <= pub_d;
    end
  end

  assign mux_sel_o      = mux_sel_q;
  assign mux_on_o       = mux_on_q;
  assign power_down_o   = pd_q;
  assign dac_code_o     = dac_q;
  assign result_o       = result_q;
  assign result_valid_o = valid_q;
  assign busy_o         = (state_q != S_IDLE);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  property p_bbm;
    $changed(mux_sel_q) |-> !$past(mux_on_q);
  endproperty
  a_bbm: assert property (p_bbm)
    else $error("input switched while connected");

  property p_pwrdn;
    cmd_ev && ev_cmd == CMD_PWRDN |=> pd_q && !mux_on_q && first_q;
  endproperty
  a_pwrdn: assert property (p_pwrdn)
    else $error("power-down not applied");

  property p_cfg_wr;
    frm_ev && ev_fcmd == CMD_CFG_WR |=> cfg_q == $past(ev_data);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("config write lost");

  property p_first;
    done_d && first_q |=> !valid_q ##1 !first_q;
  endproperty
  a_first: assert property (p_first)
    else $error("first result not marked invalid");

  property p_rsvd;
    cmd_ev && ev_cmd == CMD_RSVD && !frm_ev && state_q == S_IDLE |=>
      state_q == S_IDLE && $stable(cfg_q) && $stable(pd_q);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved code acted on");

  property p_test;
    cmd_ev && ev_cmd == CMD_TST_LO ##1 !cmd_ev [*8] |->
      mux_on_q && mux_sel_q == MUX_TST_LO;
  endproperty
  a_test: assert property (p_test)
    else $error("lower reference test not connected");

  property p_chan;
    start |-> ##[1:MAKE_MAX] (mux_on_q && mux_sel_q == tgt_q) || cmd_ev;
  endproperty
  a_chan: assert property (p_chan)
    else $error("selected input not connected in time");

  property p_sar;
    state_q == S_DECIDE && !comp_s && !cmd_ev |=>
      dac_q[$past(bit_q)] == 1'b0;
  endproperty
  a_sar: assert property (p_sar)
    else $error("trial bit kept against comparator");

endmodule

/* tb/adcscd_host.sv */
`timescale 1ns/10ps
module adcscd_host (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      fs_o,
  output logic      sdi_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_n_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    fs_o = 1'b1;
    sdi_o = 1'b0;
  end

  // one frame; serial clock runs only inside it
  task automatic xfer(input logic [15:0] w, input bit strb,
                      input int extra, output logic [15:0] r,
                      output logic fl);
    r = 16'h0000;
    fs_o = ~strb;
    #3 cs_n_o = 1'b0;
    if (strb) begin
      #3 fs_o = 1'b1;
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
      #1 fs_o = 1'b0;
    end
    for (int i = 15; i >= 0; i--) begin
      // data in moves just after each falling clock edge
      #1 sdi_o = w[i];
      #2 sclk_o = 1'b1;
      if (!strb) r[i] = sdo_i;
      #3 if (strb) r[i] = sdo_i;
      sclk_o = 1'b0;
    end
    // surplus edges with ones on the data line
    for (int k = 0; k < extra; k++) begin
      sdi_o = 1'b1;
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
    end
    #3 fl = sdo_oe_n_i;
    cs_n_o = 1'b1;
    sdi_o = ~w[0];
    fs_o = ~fs_o;
    // idle gap so the link words refresh
    #320;
  endtask
endmodule

/* tb/test_adc_serial_command_decoder.sv */
`timescale 1ns/10ps
module test_adc_serial_command_decoder
  import adcscd_pkg::*;
;
  logic        ref_clk, reset, comp_hi;
  logic        sclk, cs_n, fs, sdi, sdo, sdo_oe_n;
  logic [3:0]  mux_sel, prev_sel;
  logic        mux_on, prev_on, power_down, result_valid, busy, prev_busy;
  logic [11:0] dac_code, result, last_code, cfg;
  logic [11:0] vin [16];
  logic [12:0] exp_q [$];
  logic [15:0] r;
  logic        fl, ok_valid;
  int          fail_count, num_checks;

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // comparator of the sampled source against the trial code
  assign comp_hi = (vin[mux_sel] >= dac_code);

  adcscd_top #(.EIGHT_CH(1'b1)) dut (
    .ref_clk_i(ref_clk), .reset_i(reset), .sclk_i(sclk), .cs_n_i(cs_n),
    .frame_strobe_i(fs), .sdi_i(sdi), .comp_hi_i(comp_hi),
    .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .mux_sel_o(mux_sel),
    .mux_on_o(mux_on), .power_down_o(power_down), .dac_code_o(dac_code),
    .result_o(result), .result_valid_o(result_valid), .busy_o(busy)
  );

  adcscd_host host (
    .sclk_o(sclk), .cs_n_o(cs_n), .fs_o(fs), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic conv(input logic [3:0] cmd, input logic [3:0] sel,
                      input bit strb);
    host.xfer({cmd, 12'h000}, strb, 0, r, fl);
    if (!strb) chk({4'h0, r[15:4]}, {4'h0, last_code});
    exp_q.push_back({ok_valid, vin[sel]});
    last_code = vin[sel];
    ok_valid = 1'b1;
    chk({12'h000, mux_sel}, {12'h000, sel});
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    chk({15'h0000, busy}, 16'h0000);
  endtask

  // result monitor and break-before-make watch
  always @(negedge ref_clk) begin
    if (!reset && prev_busy === 1'b1 && busy === 1'b0) begin
      if (exp_q.size() == 0) chk(16'hffff, 16'h0000);
      else chk({3'h0, result_valid, result},
               {3'h0, exp_q.pop_front()});
    end
    if (!reset && mux_sel !== prev_sel)
      chk({15'h0000, prev_on}, 16'h0000);
    prev_busy <= busy;
    prev_sel <= mux_sel;
    prev_on <= mux_on;
  end

  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    prev_busy = 1'b0;
    prev_sel = 4'h0;
    prev_on = 1'b0;
    last_code = RESULT_RESET;
    ok_valid = 1'b0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(32'h909b));
    for (int i = 0; i < 16; i++) vin[i] = (i < 8) ? 12'($urandom) : 12'h000;
    vin[8] = 12'h800;
    vin[10] = 12'hfff;
    cfg = 12'($urandom) & 12'hf9f;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    host.xfer(16'ha000, 0, 0, r, fl);
    host.xfer({CMD_CFG_WR, cfg}, 0, 3, r, fl);
    chk({15'h0000, fl}, 16'h0001);
    host.xfer({CMD_CFG_RD, 12'h000}, 0, 0, r, fl);
    chk({4'h0, r[11:0]}, {4'h0, cfg});
    for (int i = 0; i < 11; i++) conv(4'((i < 8) ? i : i + 3), 4'(i), 0);
    host.xfer({CMD_FIFO_RD, 12'h000}, 0, 0, r, fl);
    chk(r, {last_code, PAD_NIBBLE});
    host.xfer({CMD_PWRDN, 12'h000}, 0, 0, r, fl);
    chk({15'h0000, power_down}, 16'h0001);
    ok_valid = 1'b0;
    conv(4'h3, 4'h3, 0);
    conv(4'h6, 4'h6, 0);
    host.xfer({CMD_RSVD, 12'h5a5}, 0, 0, r, fl);
    chk({11'h000, power_down, mux_sel}, 16'h0006);
    host.xfer({CMD_CFG_WR, cfg | 12'h020}, 0, 0, r, fl);
    host.xfer({CMD_CFG_RD, 12'h000}, 0, 0, r, fl);
    chk({4'h0, r[15:4]}, {4'h0, last_code});
    host.xfer({CMD_CFG_WR, cfg}, 1, 0, r, fl);
    conv(4'h5, 4'h5, 1);
    host.xfer({CMD_CFG_RD, 12'h000}, 0, 0, r, fl);
    chk({4'h0, r[11:0]}, {4'h0, cfg});
    tally_and_finish();
  end
endmodule
